// [logic/pmt_pkg.sv]
// constants and types for the MAC-side test frame and loopback block
// What this block does
// [R01] generator gap length in bytes, resets twelve
// [R02] upper count register is bits 31:16, reset zero
// [R03] lower count register is bits 15:0, reset 256
// [R04] enable or restart begins run of programmed count
// [R05] finished flag bit 0 set after last frame
// [R06] finished flag latches high, cleared by read
// [R07] host-side loop returns MAC transmit to MAC receive
// [R08] host loop with tx quiet blocks PHY transmit while line loop and generator are off
// [R09] line-side loop returns PHY receive to transmitter while generator is off
// [R10] line loop with rx quiet blocks MAC receive while host loop is off
// [R11] receive start indication only when enabled
// [R12] receive start on delimiter or on data valid
// [R13] start indication holds until frame ends
// [R14] length check asserts after eight bytes without delimiter
// [R15] transmit start indication only when enabled
// [R16] transmit start on delimiter when mode set
// [R17] transmit preamble length check, reset zero
// [R18] generator enabled means PHY data from generator
// [R19] continuous runs forever, burst stops after count
// [R20] interrupt event after count when enabled
// [R21] continuous mode never sets finished flag
package pmt_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_GEN_ENABLE   = 16'h8020;
   localparam logic [15:0] IDX_GEN_CONTROL  = 16'h8021;
   localparam logic [15:0] IDX_GEN_CONT     = 16'h8022;
   localparam logic [15:0] IDX_GEN_IRQ_EN   = 16'h8023;
   localparam logic [15:0] IDX_GEN_GAP      = 16'h8026;
   localparam logic [15:0] IDX_GEN_CNT_HI   = 16'h8027;
   localparam logic [15:0] IDX_GEN_CNT_LO   = 16'h8028;
   localparam logic [15:0] IDX_GEN_FINISHED = 16'h8029;
   localparam logic [15:0] IDX_GEN_STATUS   = 16'h802A;
   localparam logic [15:0] IDX_LOOPBACK     = 16'h8055;
   localparam logic [15:0] IDX_SOP_CTRL     = 16'h805A;

   // reset values
   localparam logic [15:0] RST_GAP    = 16'h000C;
   localparam logic [15:0] RST_CNT_HI = 16'h0000;
   localparam logic [15:0] RST_CNT_LO = 16'h0100;
   localparam logic [3:0]  RST_LOOP   = 4'hA;
   localparam logic [5:0]  RST_SOP    = 6'h1B;

   // field positions
   localparam int BIT_RESTART       = 3;
   localparam int BIT_HOST_LOOP     = 0;
   localparam int BIT_HOST_TX_QUIET = 1;
   localparam int BIT_LINE_LOOP     = 2;
   localparam int BIT_LINE_RX_QUIET = 3;
   localparam int BIT_RX_SOP_EN     = 0;
   localparam int BIT_RX_SOP_DELIM  = 1;
   localparam int BIT_RX_SOP_LEN    = 2;
   localparam int BIT_TX_SOP_EN     = 3;
   localparam int BIT_TX_SOP_DELIM  = 4;
   localparam int BIT_TX_SOP_LEN    = 5;

   // frame bytes
   localparam logic [7:0] BYTE_PREAMBLE = 8'h55;
   localparam logic [7:0] BYTE_SFD      = 8'hD5;
   localparam logic [3:0] PREAMBLE_LEN  = 4'h8;
   localparam logic [3:0] SOP_LIMIT     = 4'h8;

   typedef enum logic [1:0] {
      GEN_IDLE,
      GEN_PREAMBLE,
      GEN_BODY,
      GEN_GAP
   } pmt_gen_state_type;
endpackage : pmt_pkg

// [logic/pmt_test_frames.sv]
// test frame generator, MAC-side loopbacks and start-of-packet indication
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/100ps
module pmt_test_frames #(
   parameter logic [15:0] BODY_BYTES = 16'h0040
) (
   input  wire logic        MCLK,
   input  wire logic        ARST_N,
   input  wire logic        CYC_I,
   input  wire logic        STB_I,
   input  wire logic        WE_I,
   input  wire logic [17:0] ADR_I,
   input  wire logic [3:0]  SEL_I,
   input  wire logic [31:0] DAT_I,
   output logic      [31:0] DAT_O,
   output logic             ACK_O,
   input  wire logic [7:0]  MAC_TXD,
   input  wire logic        MAC_TX_EN,
   output logic      [7:0]  MAC_RXD,
   output logic             MAC_RX_DV,
   output logic             MAC_RX_SOP,
   output logic             MAC_TX_SOP,
   output logic      [7:0]  PHY_TXD,
   output logic             PHY_TX_EN,
   input  wire logic [7:0]  PHY_RXD,
   input  wire logic        PHY_RX_DV,
   output logic             GEN_IRQ_EVENT
);

   // register state
   logic        gen_enable;
   logic        gen_enable_q;
   logic        gen_continuous_mode;
   logic        gen_interrupt_enable;
   logic [15:0] gen_gap_bytes;
   logic [15:0] gen_count_upper;
   logic [15:0] gen_count_lower;
   logic        gen_finished_flag;
   logic [3:0]  loopback_config;
   logic [5:0]  packet_start_indication_ctrl;

   // bus decode
   logic        bus_req;
   logic        wr_stb;
   logic        rd_stb;
   logic [15:0] idx;
   logic [15:0] next_rdata;
   logic        restart_pulse;
   logic        start_run;

   // generator
   pmt_pkg::pmt_gen_state_type gen_state;
   logic [15:0] byte_cnt;
   logic [31:0] frames_left;
   logic [7:0]  gen_data;
   logic        gen_txd_en;
   logic [7:0]  gen_txd;
   logic        gen_last_frame;
   logic        gen_finish;

   // datapath
   logic [7:0]  next_phy_txd;
   logic        next_phy_tx_en;
   logic [7:0]  next_mac_rxd;
   logic        next_mac_rx_dv;

   // write lane merge for 16-bit registers
   function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  sel);
      logic [15:0] res;
      res = old_v;
      if (sel[0]) begin
         res[7:0] = wdat[7:0];
      end
      if (sel[1]) begin
         res[15:8] = wdat[15:8];
      end
      return res;
   endfunction : merge16

   assign bus_req = CYC_I & STB_I & ~ACK_O;
   assign wr_stb  = bus_req & WE_I;
   assign rd_stb  = bus_req & ~WE_I;
   assign idx     = ADR_I[17:2];

   // single-cycle acknowledge, dropped the cycle after
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= bus_req;
      end
   end

   // read mux
   always_comb begin
      next_rdata = 16'h0000;
      if (idx == pmt_pkg::IDX_GEN_ENABLE) begin
         next_rdata[0] = gen_enable;
      end else if (idx == pmt_pkg::IDX_GEN_CONT) begin
         next_rdata[0] = gen_continuous_mode;
      end else if (idx == pmt_pkg::IDX_GEN_IRQ_EN) begin
         next_rdata[0] = gen_interrupt_enable;
      end else if (idx == pmt_pkg::IDX_GEN_GAP) begin
         next_rdata = gen_gap_bytes;
      end else if (idx == pmt_pkg::IDX_GEN_CNT_HI) begin
         next_rdata = gen_count_upper;
      end else if (idx == pmt_pkg::IDX_GEN_CNT_LO) begin
         next_rdata = gen_count_lower;
      end else if (idx == pmt_pkg::IDX_GEN_FINISHED) begin
         next_rdata[0] = gen_finished_flag;
      end else if (idx == pmt_pkg::IDX_GEN_STATUS) begin
         next_rdata[0] = (gen_state != pmt_pkg::GEN_IDLE);
      end else if (idx == pmt_pkg::IDX_LOOPBACK) begin
         next_rdata[3:0] = loopback_config;
      end else if (idx == pmt_pkg::IDX_SOP_CTRL) begin
         next_rdata[5:0] = packet_start_indication_ctrl;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         DAT_O <= 32'h0000_0000;
      end else if (rd_stb) begin
         DAT_O <= {16'h0000, next_rdata};
      end
   end

   // writable registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gen_enable                   <= 1'b0;
         gen_continuous_mode          <= 1'b0;
         gen_interrupt_enable         <= 1'b0;
         gen_gap_bytes                <= pmt_pkg::RST_GAP;    // R01
         gen_count_upper              <= pmt_pkg::RST_CNT_HI; // R02
         gen_count_lower              <= pmt_pkg::RST_CNT_LO; // R03
         loopback_config              <= pmt_pkg::RST_LOOP;
         packet_start_indication_ctrl <= pmt_pkg::RST_SOP;
      end else if (wr_stb && SEL_I[0]) begin
         if (idx == pmt_pkg::IDX_GEN_ENABLE) begin
            gen_enable <= DAT_I[0];
         end else if (idx == pmt_pkg::IDX_GEN_CONT) begin
            gen_continuous_mode <= DAT_I[0];
         end else if (idx == pmt_pkg::IDX_GEN_IRQ_EN) begin
            gen_interrupt_enable <= DAT_I[0];
         end else if (idx == pmt_pkg::IDX_GEN_GAP) begin
            gen_gap_bytes <= merge16(gen_gap_bytes, DAT_I, SEL_I);
         end else if (idx == pmt_pkg::IDX_GEN_CNT_HI) begin
            gen_count_upper <= merge16(gen_count_upper, DAT_I, SEL_I);
         end else if (idx == pmt_pkg::IDX_GEN_CNT_LO) begin
            gen_count_lower <= merge16(gen_count_lower, DAT_I, SEL_I);
         end else if (idx == pmt_pkg::IDX_LOOPBACK) begin
            loopback_config <= DAT_I[3:0];
         end else if (idx == pmt_pkg::IDX_SOP_CTRL) begin
            packet_start_indication_ctrl <= DAT_I[5:0];
         end
      end else if (wr_stb && SEL_I[1]) begin
         if (idx == pmt_pkg::IDX_GEN_GAP) begin
            gen_gap_bytes <= merge16(gen_gap_bytes, DAT_I, SEL_I);
         end else if (idx == pmt_pkg::IDX_GEN_CNT_HI) begin
            gen_count_upper <= merge16(gen_count_upper, DAT_I, SEL_I);
         end else if (idx == pmt_pkg::IDX_GEN_CNT_LO) begin
            gen_count_lower <= merge16(gen_count_lower, DAT_I, SEL_I);
         end
      end
   end

   // self-clearing restart, rising enable also starts a run
   assign restart_pulse = wr_stb & SEL_I[0] & (idx == pmt_pkg::IDX_GEN_CONTROL)
                          & DAT_I[pmt_pkg::BIT_RESTART];
   assign start_run = gen_enable & (~gen_enable_q | restart_pulse); // R04

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gen_enable_q <= 1'b0;
      end else begin
         gen_enable_q <= gen_enable;
      end
   end

   // generator sequencing
   assign gen_last_frame = ~gen_continuous_mode & (frames_left == 32'h0000_0001); // R19
   assign gen_finish = (gen_state == pmt_pkg::GEN_BODY) & (byte_cnt == BODY_BYTES - 16'h0001)
                       & gen_last_frame & ~start_run & gen_enable;

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gen_state   <= pmt_pkg::GEN_IDLE;
         byte_cnt    <= 16'h0000;
         frames_left <= 32'h0000_0000;
         gen_data    <= 8'h00;
      end else if (!gen_enable) begin
         gen_state <= pmt_pkg::GEN_IDLE;
         byte_cnt  <= 16'h0000;
      end else if (start_run) begin
         frames_left <= {gen_count_upper, gen_count_lower}; // R04
         byte_cnt    <= 16'h0000;
         gen_data    <= 8'h00;
         if ({gen_count_upper, gen_count_lower} == 32'h0000_0000 && !gen_continuous_mode) begin
            gen_state <= pmt_pkg::GEN_IDLE;
         end else begin
            gen_state <= pmt_pkg::GEN_PREAMBLE;
         end
      end else begin
         case (gen_state)
            pmt_pkg::GEN_PREAMBLE: begin
               if (byte_cnt == {12'h000, pmt_pkg::PREAMBLE_LEN} - 16'h0001) begin
                  byte_cnt  <= 16'h0000;
                  gen_state <= pmt_pkg::GEN_BODY;
               end else begin
                  byte_cnt <= byte_cnt + 16'h0001;
               end
            end
            pmt_pkg::GEN_BODY: begin
               gen_data <= gen_data + 8'h01;
               if (byte_cnt == BODY_BYTES - 16'h0001) begin
                  byte_cnt <= 16'h0000;
                  if (gen_last_frame) begin
                     gen_state <= pmt_pkg::GEN_IDLE; // R19
                  end else begin
                     if (!gen_continuous_mode) begin
                        frames_left <= frames_left - 32'h0000_0001;
                     end
                     if (gen_gap_bytes == 16'h0000) begin
                        gen_state <= pmt_pkg::GEN_PREAMBLE;
                     end else begin
                        gen_state <= pmt_pkg::GEN_GAP;
                     end
                  end
               end else begin
                  byte_cnt <= byte_cnt + 16'h0001;
               end
            end
            pmt_pkg::GEN_GAP: begin
               if (byte_cnt == gen_gap_bytes - 16'h0001) begin // R01
                  byte_cnt  <= 16'h0000;
                  gen_state <= pmt_pkg::GEN_PREAMBLE;
               end else begin
                  byte_cnt <= byte_cnt + 16'h0001;
               end
            end
            default: begin
               gen_state <= pmt_pkg::GEN_IDLE;
            end
         endcase
      end
   end

   // generator byte stream
   always_comb begin
      gen_txd_en = 1'b0;
      gen_txd    = 8'h00;
      if (gen_state == pmt_pkg::GEN_PREAMBLE) begin
         gen_txd_en = 1'b1;
         if (byte_cnt == {12'h000, pmt_pkg::PREAMBLE_LEN} - 16'h0001) begin
            gen_txd = pmt_pkg::BYTE_SFD;
         end else begin
            gen_txd = pmt_pkg::BYTE_PREAMBLE;
         end
      end else if (gen_state == pmt_pkg::GEN_BODY) begin
         gen_txd_en = 1'b1;
         gen_txd    = gen_data;
      end
   end

   // finished flag: set wins over clear-on-read
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         gen_finished_flag <= 1'b0;
      end else if (gen_finish) begin
         gen_finished_flag <= 1'b1; // R05 R21
      end else if (rd_stb && idx == pmt_pkg::IDX_GEN_FINISHED) begin
         gen_finished_flag <= 1'b0; // R06
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         GEN_IRQ_EVENT <= 1'b0;
      end else begin
         GEN_IRQ_EVENT <= gen_finish & gen_interrupt_enable; // R20
      end
   end

   // transmit and receive steering
   always_comb begin
      next_phy_txd   = MAC_TXD;
      next_phy_tx_en = MAC_TX_EN;
      if (gen_enable) begin
         next_phy_txd   = gen_txd; // R18
         next_phy_tx_en = gen_txd_en;
      end else if (loopback_config[pmt_pkg::BIT_LINE_LOOP]) begin
         next_phy_txd   = PHY_RXD; // R09
         next_phy_tx_en = PHY_RX_DV;
      end else if (loopback_config[pmt_pkg::BIT_HOST_LOOP] &&
                   loopback_config[pmt_pkg::BIT_HOST_TX_QUIET]) begin
         next_phy_txd   = 8'h00; // R08
         next_phy_tx_en = 1'b0;
      end
   end

   always_comb begin
      next_mac_rxd   = PHY_RXD;
      next_mac_rx_dv = PHY_RX_DV;
      if (loopback_config[pmt_pkg::BIT_HOST_LOOP]) begin
         next_mac_rxd   = MAC_TXD; // R07
         next_mac_rx_dv = MAC_TX_EN;
      end else if (loopback_config[pmt_pkg::BIT_LINE_LOOP] &&
                   loopback_config[pmt_pkg::BIT_LINE_RX_QUIET]) begin
         next_mac_rxd   = 8'h00; // R10
         next_mac_rx_dv = 1'b0;
      end
   end

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PHY_TXD   <= 8'h00;
         PHY_TX_EN <= 1'b0;
         MAC_RXD   <= 8'h00;
         MAC_RX_DV <= 1'b0;
      end else begin
         PHY_TXD   <= next_phy_txd;
         PHY_TX_EN <= next_phy_tx_en;
         MAC_RXD   <= next_mac_rxd;
         MAC_RX_DV <= next_mac_rx_dv;
      end
   end

   // start-of-packet detectors, lane 0 receive, lane 1 transmit
   logic [1:0]       sop_dv;
   logic [7:0]       sop_d   [2];
   logic [1:0]       sop_en;
   logic [1:0]       sop_delim;
   logic [1:0]       sop_len;
   logic [1:0]       sop_out;

   assign sop_dv[0]    = next_mac_rx_dv;
   assign sop_d[0]     = next_mac_rxd;
   assign sop_dv[1]    = next_phy_tx_en;
   assign sop_d[1]     = next_phy_txd;
   assign sop_en[0]    = packet_start_indication_ctrl[pmt_pkg::BIT_RX_SOP_EN];
   assign sop_delim[0] = packet_start_indication_ctrl[pmt_pkg::BIT_RX_SOP_DELIM];
   assign sop_len[0]   = packet_start_indication_ctrl[pmt_pkg::BIT_RX_SOP_LEN];
   assign sop_en[1]    = packet_start_indication_ctrl[pmt_pkg::BIT_TX_SOP_EN];
   assign sop_delim[1] = packet_start_indication_ctrl[pmt_pkg::BIT_TX_SOP_DELIM];
   assign sop_len[1]   = packet_start_indication_ctrl[pmt_pkg::BIT_TX_SOP_LEN];

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sop
         logic [3:0] cnt;
         logic       armed;
         logic       flag;
         always_ff @(posedge MCLK or negedge ARST_N) begin
            if (!ARST_N) begin
               cnt   <= 4'h0;
               armed <= 1'b1;
               flag  <= 1'b0;
            end else if (!sop_dv[g]) begin
               cnt   <= 4'h0; // R13
               armed <= 1'b1;
               flag  <= 1'b0;
            end else begin
               if (cnt != pmt_pkg::SOP_LIMIT) begin
                  cnt <= cnt + 4'h1;
               end
               if (!sop_en[g]) begin
                  flag <= 1'b0; // R11 R15
               end else if (flag) begin
                  flag <= 1'b1; // R13
               end else if (!sop_delim[g]) begin
                  flag <= 1'b1; // R12
               end else if (armed && sop_d[g] == pmt_pkg::BYTE_SFD) begin
                  flag <= 1'b1; // R12 R16
               end else if (armed && cnt == pmt_pkg::SOP_LIMIT - 4'h1) begin
                  flag  <= sop_len[g]; // R14 R17
                  armed <= 1'b0;
               end
            end
         end
         assign sop_out[g] = flag;
      end
   endgenerate

   assign MAC_RX_SOP = sop_out[0];
   assign MAC_TX_SOP = sop_out[1];

endmodule : pmt_test_frames

// [verification/pmt_test_frames_asserts.sv]
// port checks for the test frame and loopback block
`timescale 1ns/100ps
module pmt_test_frames_chk (
   input wire logic        MCLK,
   input wire logic        ARST_N,
   input wire logic        CYC_I,
   input wire logic        STB_I,
   input wire logic        WE_I,
   input wire logic [17:0] ADR_I,
   input wire logic [31:0] DAT_I,
   input wire logic        ACK_O,
   input wire logic        MAC_TX_EN,
   input wire logic        MAC_RX_DV,
   input wire logic        MAC_RX_SOP,
   input wire logic        MAC_TX_SOP,
   input wire logic        PHY_TX_EN,
   input wire logic        PHY_RX_DV,
   input wire logic        GEN_IRQ_EVENT
);
   logic [3:0]        lb;
   logic [5:0]        sc;
   logic              gen;
   wire  logic        wr  = CYC_I && STB_I && WE_I && !ACK_O;
   wire  logic [15:0] idx = ADR_I[17:2];
   default clocking dc @(posedge MCLK); endclocking
   default disable iff (!ARST_N);
   // shadow of the settings written over the bus
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         lb  <= pmt_pkg::RST_LOOP;
         sc  <= pmt_pkg::RST_SOP;
         gen <= 1'b0;
      end else if (wr) begin
         if (idx == pmt_pkg::IDX_LOOPBACK) lb <= DAT_I[3:0];
         if (idx == pmt_pkg::IDX_SOP_CTRL) sc <= DAT_I[5:0];
         if (idx == pmt_pkg::IDX_GEN_ENABLE) gen <= DAT_I[0];
      end
   end
   chk_ack_answer: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
      else $error("bus answer is not a one-cycle ack");
   chk_irq_pulse: assert property (GEN_IRQ_EVENT |-> gen ##1 !GEN_IRQ_EVENT)
      else $error("generator event is not a single pulse");
   chk_host_loop: assert property ($past(lb[0] && !gen) |-> MAC_RX_DV == $past(MAC_TX_EN))
      else $error("host loop does not return transmit");
   chk_host_quiet: assert property ($past(lb[1:0] == 2'h3 && !lb[2] && !gen) |-> !PHY_TX_EN)
      else $error("host loop leaks to the line");
   chk_line_loop: assert property ($past(lb[2] && !gen) |-> PHY_TX_EN == $past(PHY_RX_DV))
      else $error("line loop does not return receive");
   chk_line_quiet: assert property ($past(lb[3:2] == 2'h3 && !lb[0]) |-> !MAC_RX_DV)
      else $error("line loop leaks to the host");
   chk_rx_sop_off: assert property ($past(!sc[0]) |-> !MAC_RX_SOP)
      else $error("receive start while disabled");
   chk_rx_sop_hold: assert property (MAC_RX_SOP && MAC_RX_DV |=> MAC_RX_SOP || !MAC_RX_DV)
      else $error("receive start dropped inside frame");
   chk_tx_sop_off: assert property ($past(!sc[3]) |-> !MAC_TX_SOP)
      else $error("transmit start while disabled");
   chk_tx_sop_hold: assert property (MAC_TX_SOP && PHY_TX_EN |=> MAC_TX_SOP || !PHY_TX_EN)
      else $error("transmit start dropped inside frame");
   cover property (GEN_IRQ_EVENT);
   cover property ($rose(MAC_RX_SOP));
   cover property ($rose(MAC_TX_SOP));
endmodule : pmt_test_frames_chk

bind pmt_test_frames pmt_test_frames_chk i_chk (.MCLK, .ARST_N, .CYC_I, .STB_I, .WE_I, .ADR_I,
   .DAT_I, .ACK_O, .MAC_TX_EN, .MAC_RX_DV, .MAC_RX_SOP, .MAC_TX_SOP, .PHY_TX_EN,
   .PHY_RX_DV, .GEN_IRQ_EVENT);

// [verification/pmt_stream_model.sv]
// byte stream partner: sends frames and counts bytes and frames coming back
`timescale 1ns/100ps
module pmt_stream_model (
   input  wire logic       clk,
   output logic      [7:0] txd,
   output logic            tx_en,
   input  wire logic [7:0] rxd,
   input  wire logic       rx_dv
);
   logic [7:0] data_q = 8'h00;
   logic [7:0] idle_q = 8'h5A;
   logic       dv_q   = 1'b0;
   int         bytes_seen;
   int         frames_seen;
   int         sum_seen;
   // an idle line toggles so a stale byte never looks like data
   assign txd = tx_en ? data_q : idle_q;
   initial tx_en = 1'b0;
   always @(posedge clk) begin
      idle_q <= ~idle_q;
      dv_q <= rx_dv;
      bytes_seen <= bytes_seen + (rx_dv === 1'b1);
      frames_seen <= frames_seen + (rx_dv === 1'b1 && dv_q !== 1'b1);
      sum_seen <= sum_seen + (rx_dv === 1'b1 ? rxd : 8'h00);
   end
   task automatic send(input int npre, input logic sfd, input int nbody);
      for (int i = 0; i <= npre + nbody; i++) begin
         @(posedge clk);
         tx_en <= 1'b1;
         data_q <= (i < npre) ? 8'h55 : (i == npre && sfd) ? 8'hD5 : i[7:0];
      end
      @(posedge clk);
      tx_en <= 1'b0;
   endtask : send
endmodule : pmt_stream_model

// [verification/pmt_tb.sv]
// self-checking bench for the test frame and loopback block
`timescale 1ns/100ps
module tb;
   logic        MCLK   = 1'b0;
   logic        ARST_N = 1'b1;
   logic        CYC_I  = 1'b0;
   logic        STB_I  = 1'b0;
   logic        WE_I   = 1'b0;
   logic [17:0] ADR_I  = 18'h00000;
   logic [31:0] DAT_I  = 32'h00000000;
   logic [31:0] DAT_O, rdata;
   logic [7:0]  MAC_TXD, MAC_RXD, PHY_TXD, PHY_RXD;
   logic        ACK_O, MAC_TX_EN, MAC_RX_DV, MAC_RX_SOP, MAC_TX_SOP;
   logic        PHY_TX_EN, PHY_RX_DV, GEN_IRQ_EVENT;
   logic        rx_q = 1'b0, tx_q = 1'b0;
   logic [2:0]  m;
   int          fail_count, checks_done, cycles, idle, gap, irqs, rx_up, tx_up, f0, b0, i0;
   int          s0, s1;
   logic [15:0] lb_cfg [4] = '{16'h0001, 16'h0003, 16'h0004, 16'h000C};
   int          lb_mac [4] = '{14, 14, 14, 0};
   int          lb_phy [4] = '{14, 0, 14, 14};
   logic [2:0]  sp_mode [5] = '{3'h3, 3'h3, 3'h7, 3'h1, 3'h2};
   logic        sp_sfd [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
   int          sp_want [5] = '{1, 0, 1, 1, 0};

   pmt_test_frames #(.BODY_BYTES(16'h0004)) i_pmt_test_frames (.MCLK, .ARST_N, .CYC_I, .STB_I,
      .WE_I, .ADR_I, .SEL_I(4'h3), .DAT_I, .DAT_O, .ACK_O, .MAC_TXD, .MAC_TX_EN, .MAC_RXD,
      .MAC_RX_DV, .MAC_RX_SOP, .MAC_TX_SOP, .PHY_TXD, .PHY_TX_EN, .PHY_RXD, .PHY_RX_DV,
      .GEN_IRQ_EVENT);
   pmt_stream_model mac_side (.clk(MCLK), .txd(MAC_TXD), .tx_en(MAC_TX_EN), .rxd(MAC_RXD),
      .rx_dv(MAC_RX_DV));
   pmt_stream_model phy_side (.clk(MCLK), .txd(PHY_RXD), .tx_en(PHY_RX_DV), .rxd(PHY_TXD),
      .rx_dv(PHY_TX_EN));

   always #4 MCLK = ~MCLK;

   // gap length, event and start-indication counters, hang limit
   always @(posedge MCLK) begin
      cycles <= cycles + 1;
      idle <= PHY_TX_EN ? 0 : idle + 1;
      if (PHY_TX_EN && idle > 0) gap <= idle;
      irqs <= irqs + (GEN_IRQ_EVENT === 1'b1);
      rx_up <= rx_up + (MAC_RX_SOP === 1'b1 && !rx_q);
      tx_up <= tx_up + (MAC_TX_SOP === 1'b1 && !tx_q);
      rx_q <= (MAC_RX_SOP === 1'b1);
      tx_q <= (MAC_TX_SOP === 1'b1);
      if (cycles == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check

   task automatic bus(input logic we, input logic [15:0] idx, input logic [15:0] wd);
      @(posedge MCLK);
      CYC_I <= 1'b1;
      STB_I <= 1'b1;
      WE_I <= we;
      ADR_I <= {idx, 2'h0};
      DAT_I <= {16'h0000, wd};
      do @(posedge MCLK); while (ACK_O !== 1'b1);
      rdata = DAT_O;
      CYC_I <= 1'b0;
      STB_I <= 1'b0;
   endtask : bus

   task automatic rd_chk(input logic [15:0] idx, input logic [15:0] want);
      bus(1'b0, idx, 16'h0000);
      check(rdata, {16'h0000, want});
   endtask : rd_chk

   initial begin
      ARST_N <= 1'b0;
      repeat (20) @(posedge MCLK);
      ARST_N <= 1'b1;
      rd_chk(pmt_pkg::IDX_GEN_GAP, 16'h000C);
      rd_chk(pmt_pkg::IDX_GEN_CNT_HI, 16'h0000);
      rd_chk(pmt_pkg::IDX_GEN_CNT_LO, 16'h0100);
      rd_chk(pmt_pkg::IDX_GEN_FINISHED, 16'h0000);
      rd_chk(pmt_pkg::IDX_LOOPBACK, 16'h000A);
      rd_chk(pmt_pkg::IDX_SOP_CTRL, 16'h001B);
      rd_chk(16'h0100, 16'h0000);
      bus(1'b1, pmt_pkg::IDX_GEN_CNT_HI, 16'hA5A5);
      rd_chk(pmt_pkg::IDX_GEN_CNT_HI, 16'hA5A5);
      bus(1'b1, pmt_pkg::IDX_GEN_CNT_HI, 16'h0000);
      bus(1'b1, pmt_pkg::IDX_GEN_CNT_LO, 16'h0003);
      bus(1'b1, pmt_pkg::IDX_GEN_GAP, 16'h0005);
      bus(1'b1, pmt_pkg::IDX_GEN_IRQ_EN, 16'h0001);
      rd_chk(pmt_pkg::IDX_GEN_IRQ_EN, 16'h0001);
      // first run by enable, second by restart, MAC traffic alongside
      for (int r = 0; r < 2; r++) begin
         f0 = phy_side.frames_seen;
         b0 = phy_side.bytes_seen;
         i0 = irqs;
         s0 = phy_side.sum_seen;
         bus(1'b1, r ? pmt_pkg::IDX_GEN_CONTROL : pmt_pkg::IDX_GEN_ENABLE, r ? 16'h8 : 16'h1);
         mac_side.send(7, 1'b1, 10);
         repeat (150) @(posedge MCLK);
         check(phy_side.frames_seen - f0, 3);
         check(phy_side.bytes_seen - b0, 36);
         check(phy_side.sum_seen - s0, 2490);
         check(gap, 5);
         check(irqs - i0, 1);
         rd_chk(pmt_pkg::IDX_GEN_FINISHED, 16'h0001);
         rd_chk(pmt_pkg::IDX_GEN_FINISHED, 16'h0000);
      end
      rd_chk(pmt_pkg::IDX_GEN_CONTROL, 16'h0000);
      bus(1'b1, pmt_pkg::IDX_GEN_CONT, 16'h0001);
      f0 = phy_side.frames_seen;
      bus(1'b1, pmt_pkg::IDX_GEN_CONTROL, 16'h0008);
      repeat (200) @(posedge MCLK);
      check(phy_side.frames_seen - f0 > 6, 1);
      check(irqs - i0, 1);
      rd_chk(pmt_pkg::IDX_GEN_FINISHED, 16'h0000);
      rd_chk(pmt_pkg::IDX_GEN_STATUS, 16'h0001);
      bus(1'b1, pmt_pkg::IDX_GEN_ENABLE, 16'h0000);
      bus(1'b1, pmt_pkg::IDX_GEN_CONT, 16'h0000);
      repeat (30) @(posedge MCLK);
      rd_chk(pmt_pkg::IDX_GEN_STATUS, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         bus(1'b1, pmt_pkg::IDX_LOOPBACK, lb_cfg[k]);
         f0 = mac_side.bytes_seen;
         b0 = phy_side.bytes_seen;
         s0 = mac_side.sum_seen;
         s1 = phy_side.sum_seen;
         if (k < 2) mac_side.send(7, 1'b1, 6);
         else phy_side.send(7, 1'b1, 6);
         repeat (5) @(posedge MCLK);
         check(mac_side.bytes_seen - f0, lb_mac[k]);
         check(phy_side.bytes_seen - b0, lb_phy[k]);
         check(mac_side.sum_seen - s0, lb_mac[k] ? 871 : 0);
         check(phy_side.sum_seen - s1, lb_phy[k] ? 871 : 0);
      end
      bus(1'b1, pmt_pkg::IDX_LOOPBACK, 16'h0000);
      // receive cases first, then the same modes on the transmit side
      for (int k = 0; k < 10; k++) begin
         m = sp_mode[k % 5];
         bus(1'b1, pmt_pkg::IDX_SOP_CTRL, k < 5 ? {10'h000, 3'h3, m} : {10'h000, m, 3'h3});
         f0 = rx_up;
         b0 = tx_up;
         if (k < 5) phy_side.send(7, sp_sfd[k % 5], 6);
         else mac_side.send(7, sp_sfd[k % 5], 6);
         repeat (6) @(posedge MCLK);
         check(k < 5 ? rx_up - f0 : tx_up - b0, sp_want[k % 5]);
      end
      report_and_stop();
   end
endmodule : tb
